// ### pxr_pkg.sv
package pxr_pkg;
	// response opcodes
	localparam logic [3:0]  RES_PASS     = 4'h1;
	localparam logic [3:0]  RES_FAIL     = 4'h2;
	localparam logic [3:0]  RES_UNKNOWN  = 4'h3;
	// command codes that shape the answer
	localparam logic [3:0]  CMD_SINGLE   = 4'h4;
	localparam logic [3:0]  CMD_ROW      = 4'h5;
	localparam logic [3:0]  CMD_BLANK    = 4'ha;
	localparam logic [3:0]  CMD_VER      = 4'hb;
	// query or error byte values
	localparam logic [7:0]  QE_NONE      = 8'h00;
	localparam logic [7:0]  QE_VERIFY    = 8'h01;
	localparam logic [7:0]  QE_OTHER     = 8'h02;
	localparam logic [7:0]  QE_BLANK     = 8'hf0;
	localparam logic [7:0]  QE_NOT_BLANK = 8'h0f;
	// completion status from the executive core
	localparam logic [1:0]  ERR_NONE     = 2'h0;
	localparam logic [1:0]  ERR_VERIFY   = 2'h1;
	// header layout
	localparam logic [15:0] HDR_WORDS    = 16'h0002;
	localparam int          HDR_OPC_LSB  = 12;
	localparam int          HDR_CMD_LSB  = 8;
	// register byte offsets
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_VERSION  = 8'h04;
	localparam logic [7:0]  ADDR_NVM      = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_EN   = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h14;
	localparam logic [7:0]  ADDR_STATUS   = 8'h18;
	// reset values
	localparam logic        CTRL_RST     = 1'b1;
	localparam logic [7:0]  VERSION_RST  = 8'h10;
	localparam logic [15:0] NVM_RST      = 16'h0000;
	localparam logic [3:0]  IRQ_EN_RST   = 4'h0;
	// nonvolatile control write bit
	localparam int          NVM_WR_BIT   = 15;
	// interrupt event bits
	localparam int          EV_RSP_DONE  = 0;
	localparam int          EV_FAIL      = 1;
	localparam int          EV_UNKNOWN   = 2;
	localparam int          EV_NVM_DONE  = 3;
	localparam int          N_EV         = 4;

	typedef enum logic [1:0] {ST_IDLE, ST_HDR0, ST_HDR1, ST_DATA} pxr_state_t;
	typedef enum logic [1:0] {W_HDR0, W_HDR1, W_DATA} pxr_word_t;
endpackage : pxr_pkg

// ### pxr_len_calc.sv
`timescale 1ns/100ps
module pxr_len_calc (
	input  wire logic        i_is_read,
	input  wire logic [15:0] i_n_words,
	output logic      [15:0] o_len
);
	logic [16:0] pairs;
	logic [18:0] len_wide;

	// packed format: three words per pair, odd last word padded to a pair
	always_comb begin
		pairs    = 17'(({1'b0, i_n_words} + 17'h1) >> 1);
		len_wide = 19'({2'b00, pairs} * 19'h3) + 19'h2;
		o_len    = i_is_read ? len_wide[15:0] : pxr_pkg::HDR_WORDS; // [RULE12]
	end
endmodule : pxr_len_calc

// ### pxr_irq.sv
`timescale 1ns/100ps
module pxr_irq (
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst,
	input  wire logic [pxr_pkg::N_EV-1:0] i_event,
	input  wire logic [pxr_pkg::N_EV-1:0] i_clear,
	input  wire logic [pxr_pkg::N_EV-1:0] i_enable,
	output logic      [pxr_pkg::N_EV-1:0] o_status,
	output logic                          o_irq
);
	typedef struct packed {
		logic [pxr_pkg::N_EV-1:0] status;
	} pxr_irq_state_t;

	pxr_irq_state_t st;
	pxr_irq_state_t next_st;

	// an event in the clearing cycle survives the clear
	always_comb begin
		next_st = st;
		for (int i = 0; i < pxr_pkg::N_EV; i++) begin
			next_st.status[i] = i_event[i] | (st.status[i] & ~i_clear[i]);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_status = st.status;
	assign o_irq    = |(st.status & i_enable);
endmodule : pxr_irq

// ### pxr_resp_gen.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
// What the document asks for
// [RULE1] opcode pass 1h, fail 2h, unknown 3h
// [RULE2] two header words, then only data words
// [RULE3] pass, fail with reason, unknown gets unknown
// [RULE4] header bits 11:8 echo command code
// [RULE5] one command at a time, one response
// [RULE6] queries always pass, answer in low byte
// [RULE7] blank check answers f0h blank, 0fh not
// [RULE8] version byte: main nibble high, revision low
// [RULE9] error byte 0h ok, 1h verify, 2h other
// [RULE10] length word counts all words incl header
// [RULE11] all non-read responses are two words
// [RULE12] read length 3*ceil(N/2)+2 words
// [RULE13] programmer erases, then programs 64-word rows
// [RULE14] programmer writes 4042h before erase start
// [RULE15] second page erase at pointer plus 400h
// [RULE16] programmer writes 4001h for row program
// [RULE17] hardware clears write bit 15 on completion
// [RULE18] every command gets a status response
// [RULE19] answer only after work and verify finish
module pxr_resp_gen #(
	// read command code, arbitrary default
	parameter logic [3:0] READ_CMD = 4'h2
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic        i_cmd_valid,
	output logic             o_cmd_ready,
	input  wire logic [3:0]  i_cmd_code,
	input  wire logic        i_cmd_known,
	input  wire logic [1:0]  i_cmd_err,
	input  wire logic        i_cmd_blank,
	input  wire logic [15:0] i_cmd_n_words,
	input  wire logic        i_rd_valid,
	input  wire logic [15:0] i_rd_data,
	output logic             o_rd_ready,
	output logic             o_rsp_valid,
	output logic      [15:0] o_rsp_word,
	output logic             o_rsp_last,
	input  wire logic        i_rsp_ready,
	output logic             o_nvm_start,
	output logic      [14:0] o_nvm_op,
	input  wire logic        i_nvm_done,
	output logic             o_irq
);
	typedef struct packed {
		pxr_pkg::pxr_state_t state;
		logic                out_valid;
		logic [15:0]         out_word;
		logic                out_last;
		pxr_pkg::pxr_word_t  out_kind;
		logic [15:0]         hdr0;
		logic [15:0]         len;
		logic [15:0]         remain;
		logic                enable;
		logic [7:0]          version;
		logic [15:0]         nvm;
		logic                nvm_start;
		logic [3:0]          irq_en;
		logic                ack;
		logic [31:0]         rdata;
	} pxr_top_state_t;

	pxr_top_state_t st;
	pxr_top_state_t next_st;

	logic                     acc;
	logic                     take;
	logic                     wr;
	logic                     rd_go;
	logic                     is_read;
	logic [15:0]              calc_len;
	logic [3:0]               opc;
	logic [7:0]               qe;
	logic [31:0]              wmask;
	logic [pxr_pkg::N_EV-1:0] ev;
	logic [pxr_pkg::N_EV-1:0] irq_clr;
	logic [pxr_pkg::N_EV-1:0] irq_stat;

	////////////////////////////////////////////////////////////////////////
	// helpers

	pxr_len_calc u_len (
		.i_is_read (is_read),
		.i_n_words (i_cmd_n_words),
		.o_len     (calc_len)
	);

	pxr_irq u_irq (
		.i_mclk   (i_mclk),
		.i_rst    (i_rst),
		.i_event  (ev),
		.i_clear  (irq_clr),
		.i_enable (st.irq_en),
		.o_status (irq_stat),
		.o_irq    (o_irq)
	);

	// new commands wait until the last word has left the output slot
	assign o_cmd_ready = st.enable && st.state == pxr_pkg::ST_IDLE
		&& !st.out_valid; // [RULE5]
	assign acc     = i_cmd_valid && o_cmd_ready; // [RULE19]
	assign take    = !st.out_valid || i_rsp_ready;
	assign is_read = i_cmd_known && i_cmd_code == READ_CMD;
	assign o_rd_ready = take && st.state == pxr_pkg::ST_DATA;
	assign wr    = i_wb_cyc && i_wb_stb && i_wb_we && st.ack;
	assign rd_go = i_wb_cyc && i_wb_stb && !st.ack;

	////////////////////////////////////////////////////////////////////////
	// header content

	always_comb begin
		opc = pxr_pkg::RES_PASS;
		qe  = pxr_pkg::QE_NONE;
		if (!i_cmd_known) begin
			opc = pxr_pkg::RES_UNKNOWN; // [RULE3]
		end else if (i_cmd_code == pxr_pkg::CMD_BLANK) begin
			qe = i_cmd_blank ? pxr_pkg::QE_BLANK
				: pxr_pkg::QE_NOT_BLANK; // [RULE6] [RULE7]
		end else if (i_cmd_code == pxr_pkg::CMD_VER) begin
			qe = st.version; // [RULE8]
		end else if (i_cmd_err != pxr_pkg::ERR_NONE) begin
			opc = pxr_pkg::RES_FAIL; // [RULE1]
			// verify code only belongs to the two programming commands
			if (i_cmd_err == pxr_pkg::ERR_VERIFY
				&& (i_cmd_code == pxr_pkg::CMD_SINGLE
				|| i_cmd_code == pxr_pkg::CMD_ROW)) begin
				qe = pxr_pkg::QE_VERIFY; // [RULE9]
			end else begin
				qe = pxr_pkg::QE_OTHER; // [RULE9]
			end
		end
	end

	always_comb begin
		ev = '0;
		ev[pxr_pkg::EV_RSP_DONE] = o_rsp_valid && i_rsp_ready && o_rsp_last;
		ev[pxr_pkg::EV_FAIL]     = acc && opc == pxr_pkg::RES_FAIL;
		ev[pxr_pkg::EV_UNKNOWN]  = acc && !i_cmd_known;
		ev[pxr_pkg::EV_NVM_DONE] = i_nvm_done && st.nvm[pxr_pkg::NVM_WR_BIT];
		irq_clr = '0;
		if (wr && i_wb_adr == pxr_pkg::ADDR_IRQ_CLR && i_wb_sel[0]) begin
			irq_clr = i_wb_dat[pxr_pkg::N_EV-1:0];
		end
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{i_wb_sel[b]}};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// response sequencer and registers

	always_comb begin
		next_st = st;
		next_st.nvm_start = 1'b0;
		if (o_rsp_valid && i_rsp_ready) begin
			next_st.out_valid = 1'b0;
		end
		case (st.state)
			pxr_pkg::ST_IDLE: begin
				if (acc) begin
					next_st.hdr0 = {opc, i_cmd_code, qe}; // [RULE2] [RULE4]
					next_st.len  = calc_len; // [RULE10] [RULE11]
					next_st.remain = 16'(calc_len - pxr_pkg::HDR_WORDS);
					next_st.state  = pxr_pkg::ST_HDR0;
				end
			end
			pxr_pkg::ST_HDR0: begin
				if (take) begin
					next_st.out_valid = 1'b1;
					next_st.out_word  = st.hdr0; // [RULE2] [RULE18]
					next_st.out_kind  = pxr_pkg::W_HDR0;
					next_st.out_last  = 1'b0;
					next_st.state     = pxr_pkg::ST_HDR1;
				end
			end
			pxr_pkg::ST_HDR1: begin
				if (take) begin
					next_st.out_valid = 1'b1;
					next_st.out_word  = st.len; // [RULE10]
					next_st.out_kind  = pxr_pkg::W_HDR1;
					next_st.out_last  = st.remain == 16'h0000;
					next_st.state     = st.remain == 16'h0000
						? pxr_pkg::ST_IDLE : pxr_pkg::ST_DATA;
				end
			end
			pxr_pkg::ST_DATA: begin
				if (take && i_rd_valid) begin
					next_st.out_valid = 1'b1;
					next_st.out_word  = i_rd_data; // [RULE12]
					next_st.out_kind  = pxr_pkg::W_DATA;
					next_st.out_last  = st.remain == 16'h0001;
					next_st.remain    = 16'(st.remain - 16'h0001);
					if (st.remain == 16'h0001) begin
						next_st.state = pxr_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				next_st.state = pxr_pkg::ST_IDLE;
			end
		endcase

		// hardware ends the operation; a same-cycle software write wins
		if (i_nvm_done) begin
			next_st.nvm[pxr_pkg::NVM_WR_BIT] = 1'b0; // [RULE17]
		end

		// classic wishbone: ack one cycle after the strobe, for one cycle
		next_st.ack = rd_go;
		if (rd_go) begin
			if (i_wb_adr == pxr_pkg::ADDR_CTRL) begin
				next_st.rdata = {31'h0, st.enable};
			end else if (i_wb_adr == pxr_pkg::ADDR_VERSION) begin
				next_st.rdata = {24'h0, st.version};
			end else if (i_wb_adr == pxr_pkg::ADDR_NVM) begin
				next_st.rdata = {16'h0, st.nvm};
			end else if (i_wb_adr == pxr_pkg::ADDR_IRQ_STAT) begin
				next_st.rdata = {28'h0, irq_stat};
			end else if (i_wb_adr == pxr_pkg::ADDR_IRQ_EN) begin
				next_st.rdata = {28'h0, st.irq_en};
			end else if (i_wb_adr == pxr_pkg::ADDR_STATUS) begin
				next_st.rdata = {st.hdr0, 13'h0, st.out_valid, st.state};
			end else begin
				next_st.rdata = 32'h0;
			end
		end
		if (wr) begin
			if (i_wb_adr == pxr_pkg::ADDR_CTRL && i_wb_sel[0]) begin
				next_st.enable = i_wb_dat[0];
			end else if (i_wb_adr == pxr_pkg::ADDR_VERSION && i_wb_sel[0]) begin
				next_st.version = i_wb_dat[7:0];
			end else if (i_wb_adr == pxr_pkg::ADDR_NVM) begin
				next_st.nvm = (st.nvm & ~wmask[15:0])
					| (i_wb_dat[15:0] & wmask[15:0]);
				next_st.nvm_start = next_st.nvm[pxr_pkg::NVM_WR_BIT]
					&& !st.nvm[pxr_pkg::NVM_WR_BIT];
			end else if (i_wb_adr == pxr_pkg::ADDR_IRQ_EN && i_wb_sel[0]) begin
				next_st.irq_en = i_wb_dat[3:0];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st         <= '0;
			st.enable  <= pxr_pkg::CTRL_RST;
			st.version <= pxr_pkg::VERSION_RST;
			st.nvm     <= pxr_pkg::NVM_RST;
			st.irq_en  <= pxr_pkg::IRQ_EN_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_wb_ack    = st.ack;
	assign o_wb_dat    = st.rdata;
	assign o_rsp_valid = st.out_valid;
	assign o_rsp_word  = st.out_word;
	assign o_rsp_last  = st.out_last;
	assign o_nvm_start = st.nvm_start;
	assign o_nvm_op    = st.nvm[14:0];

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_unknown_opcode: assert property ( // [RULE1] [RULE3]
		acc && !i_cmd_known |=> st.hdr0[15:12] == pxr_pkg::RES_UNKNOWN)
		else $error("unknown command not answered with unknown opcode");
	a_fail_opcode: assert property ( // [RULE1] [RULE3]
		acc && i_cmd_known && i_cmd_err != pxr_pkg::ERR_NONE
		&& i_cmd_code != pxr_pkg::CMD_BLANK && i_cmd_code != pxr_pkg::CMD_VER
		|=> st.hdr0[15:12] == pxr_pkg::RES_FAIL && st.hdr0[7:0] != 8'h00)
		else $error("failed command not answered with fail opcode");
	a_cmd_echo: assert property ( // [RULE4]
		acc |=> st.hdr0[11:8] == $past(i_cmd_code))
		else $error("command echo wrong");
	a_blank_answer: assert property ( // [RULE6] [RULE7]
		acc && i_cmd_known && i_cmd_code == pxr_pkg::CMD_BLANK
		|=> st.hdr0 == {pxr_pkg::RES_PASS, pxr_pkg::CMD_BLANK,
		($past(i_cmd_blank) ? 8'hf0 : 8'h0f)})
		else $error("blank check answer wrong");
	a_version_answer: assert property ( // [RULE6] [RULE8]
		acc && i_cmd_known && i_cmd_code == pxr_pkg::CMD_VER
		|=> st.hdr0[15:12] == pxr_pkg::RES_PASS && st.hdr0[7:0] == st.version)
		else $error("version answer wrong");
	a_verify_code: assert property ( // [RULE9]
		acc && i_cmd_known && i_cmd_err == pxr_pkg::ERR_VERIFY
		&& i_cmd_code == pxr_pkg::CMD_ROW |=> st.hdr0[7:0] == 8'h01)
		else $error("verify failure code wrong");
	a_ok_code: assert property ( // [RULE9]
		acc && i_cmd_known && i_cmd_err == pxr_pkg::ERR_NONE
		&& i_cmd_code != pxr_pkg::CMD_BLANK && i_cmd_code != pxr_pkg::CMD_VER
		|=> st.hdr0 == {pxr_pkg::RES_PASS, $past(i_cmd_code), 8'h00})
		else $error("success header wrong");
	a_len_two: assert property ( // [RULE10] [RULE11]
		acc && !is_read |=> st.len == 16'h0002)
		else $error("non-read length not two");
	a_read_len: assert property ( // [RULE12]
		acc && is_read && !i_cmd_n_words[0] && i_cmd_n_words < 16'h2000
		|=> st.len == 16'($past(i_cmd_n_words) / 2 * 3 + 2))
		else $error("read length wrong");
	a_one_cmd: assert property ( // [RULE5]
		st.state != pxr_pkg::ST_IDLE |-> !o_cmd_ready)
		else $error("second command taken while busy");
	// a word after the last one would be a second response
	a_no_extra: assert property ( // [RULE5]
		o_rsp_valid && i_rsp_ready && o_rsp_last |=> !o_rsp_valid)
		else $error("word sent after last word of response");
	a_read_len_odd: assert property ( // [RULE12]
		acc && is_read && i_cmd_n_words[0] && i_cmd_n_words < 16'h2000
		|=> st.len == 16'(($past(i_cmd_n_words) + 1) / 2 * 3 + 2))
		else $error("odd read length wrong");
	a_single_verify: assert property ( // [RULE9]
		acc && i_cmd_known && i_cmd_err == pxr_pkg::ERR_VERIFY
		&& i_cmd_code == pxr_pkg::CMD_SINGLE |=> st.hdr0[7:0] == 8'h01)
		else $error("single program verify code wrong");
	a_nvm_start: assert property ( // [RULE17]
		wr && i_wb_adr == pxr_pkg::ADDR_NVM && i_wb_sel[1]
		&& i_wb_dat[15] && !st.nvm[pxr_pkg::NVM_WR_BIT] |=> o_nvm_start)
		else $error("write bit set without start pulse");
	a_hdr_first: assert property ( // [RULE2] [RULE18] [RULE19]
		acc |-> ##2 o_rsp_valid && o_rsp_word[11:8] == $past(i_cmd_code, 2)
		&& st.out_kind == pxr_pkg::W_HDR0)
		else $error("header word not first");
	a_nvm_clear: assert property ( // [RULE17]
		i_nvm_done && !wr |=> !st.nvm[pxr_pkg::NVM_WR_BIT])
		else $error("write bit not cleared on completion");

	c_fail_resp: cover property (acc && opc == pxr_pkg::RES_FAIL);
	c_read_resp: cover property (
		st.out_kind == pxr_pkg::W_DATA && o_rsp_last && i_rsp_ready);
	c_nvm_cycle: cover property (o_nvm_start ##[1:50] i_nvm_done);
	c_unknown_resp: cover property (acc && !i_cmd_known);
	c_blank_resp: cover property (
		acc && i_cmd_known && i_cmd_code == pxr_pkg::CMD_BLANK);
endmodule : pxr_resp_gen

// ### pxr_far_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// far side: response sink, read data source, nonvolatile engine
module pxr_far_model (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_stall,
	input  wire logic        i_rd_ready,
	input  wire logic        i_nvm_start,
	output logic             o_rd_valid,
	output logic      [15:0] o_rd_data,
	output logic             o_rsp_ready,
	output logic             o_nvm_done
);
	logic [15:0] cnt;
	logic [2:0]  dly;
	logic        ph;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cnt        <= 16'h0000;
			dly        <= 3'h0;
			ph         <= 1'b0;
			o_nvm_done <= 1'b0;
		end else begin
			ph <= ~ph;
			if (o_rd_valid && i_rd_ready)
				cnt <= cnt + 16'h0001;
			// write bit cleared by the engine a few cycles after start
			o_nvm_done <= (dly == 3'h1);
			if (i_nvm_start)
				dly <= 3'h6;
			else if (dly != 3'h0)
				dly <= dly - 3'h1;
		end
	end
	// stalling mode halves both rates, phases opposed
	assign o_rsp_ready = !i_stall || ph;
	assign o_rd_valid  = !i_stall || !ph;
	// no stale data while not valid
	assign o_rd_data   = o_rd_valid ? 16'hd000 + cnt : ~(16'hd000 + cnt);
endmodule : pxr_far_model

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam logic [3:0] RD = 4'h2;
	typedef struct {
		logic [3:0]  code;
		logic        known;
		logic [1:0]  err;
		logic        blank;
		logic [15:0] n;
		logic [3:0]  opc;
		logic [7:0]  qe;
	} pxr_row_t;
	logic        i_mclk = 1'b0, i_rst = 1'b1, stall = 1'b0;
	logic        i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [7:0]  i_wb_adr = 8'h00;
	logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
	logic        o_wb_ack, i_cmd_valid = 1'b0, o_cmd_ready, i_cmd_known = 1'b0;
	logic [3:0]  i_cmd_code = 4'h0;
	logic [1:0]  i_cmd_err = 2'h0;
	logic        i_cmd_blank = 1'b0, i_rd_valid, o_rd_ready, o_rsp_valid;
	logic [15:0] i_cmd_n_words = 16'h0, i_rd_data, o_rsp_word, dcnt = 16'h0;
	logic        o_rsp_last, i_rsp_ready, o_nvm_start, i_nvm_done, o_irq;
	logic [14:0] o_nvm_op;
	logic [15:0] rq[$];
	int          mismatches = 0, compares = 0, nrsp = 0;
	pxr_row_t    rows[13] = '{
		'{pxr_pkg::CMD_SINGLE, 1, 0, 0, 0, 4'h1, 8'h00},
		'{pxr_pkg::CMD_SINGLE, 1, 1, 0, 0, 4'h2, 8'h01},
		'{pxr_pkg::CMD_ROW, 1, 1, 0, 0, 4'h2, 8'h01},
		'{pxr_pkg::CMD_ROW, 1, 2, 0, 0, 4'h2, 8'h02},
		'{4'hd, 1, 1, 0, 0, 4'h2, 8'h02},
		'{pxr_pkg::CMD_BLANK, 1, 0, 1, 0, 4'h1, 8'hf0},
		'{pxr_pkg::CMD_BLANK, 1, 2, 0, 0, 4'h1, 8'h0f},
		'{pxr_pkg::CMD_VER, 1, 3, 0, 0, 4'h1, 8'h10},
		'{4'h7, 0, 0, 0, 0, 4'h3, 8'h00},
		'{RD, 1, 0, 0, 0, 4'h1, 8'h00},
		'{RD, 1, 0, 0, 1, 4'h1, 8'h00},
		'{RD, 1, 0, 0, 3, 4'h1, 8'h00},
		'{RD, 1, 0, 0, 4, 4'h1, 8'h00}};
	pxr_resp_gen #(.READ_CMD(RD)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(4'hf),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_cmd_valid(i_cmd_valid),
		.o_cmd_ready(o_cmd_ready), .i_cmd_code(i_cmd_code),
		.i_cmd_known(i_cmd_known), .i_cmd_err(i_cmd_err),
		.i_cmd_blank(i_cmd_blank), .i_cmd_n_words(i_cmd_n_words),
		.i_rd_valid(i_rd_valid), .i_rd_data(i_rd_data),
		.o_rd_ready(o_rd_ready), .o_rsp_valid(o_rsp_valid),
		.o_rsp_word(o_rsp_word), .o_rsp_last(o_rsp_last),
		.i_rsp_ready(i_rsp_ready), .o_nvm_start(o_nvm_start),
		.o_nvm_op(o_nvm_op), .i_nvm_done(i_nvm_done), .o_irq(o_irq));
	pxr_far_model far (.i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall),
		.i_rd_ready(o_rd_ready), .i_nvm_start(o_nvm_start),
		.o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data),
		.o_rsp_ready(i_rsp_ready), .o_nvm_done(i_nvm_done));
	initial begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		if (o_rsp_valid === 1'b1 && i_rsp_ready === 1'b1) begin
			rq.push_back(o_rsp_word);
			if (o_rsp_last === 1'b1)
				nrsp++;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task report_and_stop;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// one classic cycle, unbounded wait for ack, idle cycle follows
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge i_mclk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, we, adr, dat};
		// only the watchdog ends a missing ack
		do begin
			@(posedge i_mclk);
		end while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		{i_wb_cyc, i_wb_stb} <= 2'b00;
	endtask : wb
	function automatic logic [15:0] exp_len(input pxr_row_t r);
		if (r.code != RD || !r.known)
			return 16'h0002;
		return r.n[0] ? 16'(3 * ((r.n + 1) / 2) + 2) : 16'(3 * (r.n / 2) + 2);
	endfunction : exp_len
	task run_row(input pxr_row_t r);
		int base;
		base = nrsp;
		rq.delete();
		@(posedge i_mclk);
		i_cmd_valid <= 1'b1;
		{i_cmd_code, i_cmd_known, i_cmd_err, i_cmd_blank, i_cmd_n_words} <=
			{r.code, r.known, r.err, r.blank, r.n};
		do begin
			@(posedge i_mclk);
		end while (o_cmd_ready !== 1'b1);
		i_cmd_valid <= 1'b0;
		#1 check(o_cmd_ready, 0);
		while (nrsp == base) begin
			@(posedge i_mclk);
		end
		#1 check(nrsp - base, 1);
		check(rq[0], {r.opc, r.code, r.qe});
		check(rq[1], exp_len(r));
		check(rq.size(), exp_len(r));
		for (int j = 2; j < rq.size(); j++) begin
			check(rq[j], dcnt);
			dcnt++;
		end
	endtask : run_row
	// set up, start, then poll the write bit until hardware clears it
	task nvm(input logic [15:0] val);
		wb(1, pxr_pkg::ADDR_NVM, {16'h0, val});
		// write lands at the ack edge, so look just after it
		#1 check({o_nvm_op, o_nvm_start}, {val[14:0], 1'b0});
		wb(1, pxr_pkg::ADDR_NVM, {16'h0, val | 16'h8000});
		#1 check(o_nvm_start, 1);
		do begin
			wb(0, pxr_pkg::ADDR_NVM, 32'h0);
		end while (rd[15] !== 1'b0);
		check(rd, {16'h0, val});
	endtask : nvm
////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000 mismatches++;
		report_and_stop();
	end
	initial begin
		dcnt = 16'hd000;
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		#1 check({o_cmd_ready, o_rsp_valid, o_irq, o_nvm_op}, 18'h20000);
		wb(0, pxr_pkg::ADDR_VERSION, 32'h0);
		check(rd, 32'h10);
		wb(0, pxr_pkg::ADDR_IRQ_EN, 32'h0);
		check(rd, 32'h0);
		wb(0, 8'h1c, 32'h0);
		check(rd, 32'h0);
		for (int i = 0; i < 13; i++) begin
			stall <= i[0];
			run_row(rows[i]);
		end
		rows[7].qe = 8'h32;
		wb(1, pxr_pkg::ADDR_VERSION, 32'h32);
		run_row(rows[7]);
		wb(0, pxr_pkg::ADDR_IRQ_STAT, 32'h0);
		check({o_irq, rd[3:0]}, 5'h07);
		wb(1, pxr_pkg::ADDR_IRQ_EN, 32'h2);
		#1 check(o_irq, 1);
		wb(1, pxr_pkg::ADDR_IRQ_CLR, 32'h7);
		#1 check(o_irq, 0);
		wb(1, pxr_pkg::ADDR_CTRL, 32'h0);
		#1 check(o_cmd_ready, 0);
		wb(1, pxr_pkg::ADDR_CTRL, 32'h1);
		nvm(16'h4042);
		nvm(16'h4042);
		nvm(16'h4001);
		wb(0, pxr_pkg::ADDR_IRQ_STAT, 32'h0);
		check(rd[3:0], 4'h8);
		@(posedge i_mclk);
		i_rst <= 1'b1;
		@(posedge i_mclk);
		i_rst <= 1'b0;
		#1 check({o_cmd_ready, o_rsp_valid, o_irq, o_nvm_op}, 18'h20000);
		report_and_stop();
	end
endmodule : testbench
